// file: hdl/eis_irq_front.sv
// Operation
// - Sense-select register clears on reset, hardware standby
// - Sense bits 7,6 stored, no effect
// - Sense bit zero: request while pin low
// - Sense bit one: request on falling edge
// - NMI highest priority, always accepted
// - NMI edge chosen by edge-select bit
// - NMI uses vector 7, fixed addresses
// - Request pins 0-5 use vectors 12-17
// - Pins sensed whatever their direction setting
// - Only NMI, pins 0-2 wake standby
// - Pin levels from priority A bits 7-4
// - Flag register readable, software clears flags
// - Thirty internal sources with priority bits
// - DMA-routed timer/serial requests not forwarded
// - Equal level: smaller vector wins, default
// - Priority bits raise sources, NMI fixed
// - Vector address number times four/two
// - Timers 2-4 map to 32/36/40 groups
// - DMA ends map to 44-47, bit B5
// - Reserved vectors carry no source
// - Flags set by level/edge, write-zero clears
// - Enable register clears on reset, hardware standby
`timescale 1ns/1ps
`default_nettype none
module eis_irq_front
   import eis_pkg::*;
(
   input  wire logic                 sys_clk_in,
   input  wire logic                 rst_in,
   input  wire logic                 hw_standby_in,
   input  wire logic                 sw_standby_in,
   input  wire logic                 nmi_pin_in,
   input  wire logic [NUM_PINS-1:0]  irq_pin_n_in,
   input  wire logic [NUM_INT-1:0]   int_req_in,
   input  wire logic [NUM_INT-1:0]   dma_route_in,
   input  wire logic                 ack_in,
   input  wire logic [5:0]           ack_vector_in,
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   output logic                      irq_req_out,
   output logic                      nmi_req_out,
   output logic [5:0]                vector_out,
   output logic                      level_out,
   output logic [15:0]               vec_addr_adv_out,
   output logic [15:0]               vec_addr_norm_out,
   output logic                      wake_out
);

   eis_state_t state;
   eis_state_t next_state;

   logic [NUM_PINS-1:0] pin_low;
   logic [NUM_PINS-1:0] pin_fall;
   logic [NUM_PINS-1:0] pin_set;
   logic                nmi_edge;

   ////////////////////////////////////////////////////////////////////////////
   // Per-pin sensing

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
         assign pin_low[gi]  = ~irq_pin_n_in[gi];
         assign pin_fall[gi] = state.pin_prev[gi] & ~irq_pin_n_in[gi];
         assign pin_set[gi]  = state.irq_sense_select[gi] ? pin_fall[gi]
                                                          : pin_low[gi];
      end
   endgenerate

   assign nmi_edge = state.system_control_reg[NMI_EDGE_BIT]
                     ? (~state.nmi_prev & nmi_pin_in)
                     : (state.nmi_prev & ~nmi_pin_in);

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      logic [63:0]         req_vec;
      logic [63:0]         lvl_vec;
      logic [15:0]         prio;
      logic [5:0]          clr_mask;
      logic [5:0]          pin_req;
      logic [NUM_INT-1:0]  int_fwd;
      logic                found_hi;
      logic                found_lo;
      logic [5:0]          sel_hi;
      logic [5:0]          sel_lo;
      logic                do_write;
      logic [7:0]          rd;
      logic                rd_ok;
      req_vec  = '0;
      lvl_vec  = '0;
      prio     = {state.priority_reg_b, state.priority_reg_a};
      clr_mask = '1;
      pin_req  = '0;
      int_fwd  = '0;
      found_hi = 1'b0;
      found_lo = 1'b0;
      sel_hi   = '0;
      sel_lo   = '0;
      rd       = '0;
      rd_ok    = 1'b1;
      do_write = 1'b0;
      next_state = state;

      next_state.pin_prev = irq_pin_n_in;
      next_state.nmi_prev = nmi_pin_in;

      // Bus write channels, taken in either order
      if (s_axi_awvalid && state.axi.awready) begin
         next_state.aw_got  = 1'b1;
         next_state.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && state.axi.wready) begin
         next_state.w_got   = 1'b1;
         next_state.w_data  = s_axi_wdata[7:0];
         next_state.w_lane0 = s_axi_wstrb[0];
      end
      if (state.axi.bvalid && s_axi_bready) begin
         next_state.axi.bvalid = 1'b0;
      end
      do_write = state.aw_got && state.w_got && !state.axi.bvalid;
      if (do_write) begin
         next_state.aw_got     = 1'b0;
         next_state.w_got      = 1'b0;
         next_state.axi.bvalid = 1'b1;
         next_state.axi.bresp  = RESP_OKAY;
         unique case (state.aw_addr)
            OFS_SENSE_SELECT: begin
               if (state.w_lane0) next_state.irq_sense_select = state.w_data;
            end
            OFS_ENABLE: begin
               if (state.w_lane0) next_state.irq_enable_reg = state.w_data;
            end
            OFS_FLAG: begin
               if (state.w_lane0) clr_mask = state.w_data[5:0];
            end
            OFS_PRIO_A: begin
               if (state.w_lane0) next_state.priority_reg_a = state.w_data;
            end
            OFS_PRIO_B: begin
               if (state.w_lane0) next_state.priority_reg_b = state.w_data;
            end
            OFS_SYS_CTRL: begin
               if (state.w_lane0) next_state.system_control_reg = state.w_data;
            end
            OFS_STATUS: begin
            end
            default: begin
               next_state.axi.bresp = RESP_SLVERR;
            end
         endcase
      end
      next_state.axi.awready = !next_state.aw_got && !next_state.axi.bvalid;
      next_state.axi.wready  = !next_state.w_got && !next_state.axi.bvalid;

      // Bus read channel
      unique case (s_axi_araddr)
         OFS_SENSE_SELECT: rd = state.irq_sense_select;
         OFS_ENABLE:       rd = state.irq_enable_reg;
         OFS_FLAG:         rd = {2'b00, state.irq_flag_reg};
         OFS_PRIO_A:       rd = state.priority_reg_a;
         OFS_PRIO_B:       rd = state.priority_reg_b;
         OFS_SYS_CTRL:     rd = state.system_control_reg;
         OFS_STATUS:       rd = {state.req, state.nmi_pending, state.vector};
         default:          rd_ok = 1'b0;
      endcase
      if (state.axi.rvalid && s_axi_rready) begin
         next_state.axi.rvalid = 1'b0;
      end
      if (s_axi_arvalid && state.axi.arready) begin
         next_state.axi.rvalid = 1'b1;
         next_state.axi.rdata  = {24'h000000, rd};
         next_state.axi.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      next_state.axi.arready = !next_state.axi.rvalid;

      // Acknowledge clears the taken pin flag or pending NMI
      for (int i = 0; i < NUM_PINS; i++) begin
         if (ack_in && ack_vector_in == VEC_PIN_BASE + 6'(i)
             && (state.irq_sense_select[i] || !pin_low[i])) begin
            clr_mask[i] = 1'b0;
         end
      end
      if (ack_in && ack_vector_in == VEC_NMI) begin
         next_state.nmi_pending = 1'b0;
      end
      if (nmi_edge) begin
         next_state.nmi_pending = 1'b1;
      end

      // Set wins over clear
      next_state.irq_flag_reg = (state.irq_flag_reg & clr_mask) | pin_set;

      // Candidate requests by vector number
      pin_req = state.irq_flag_reg & state.irq_enable_reg[5:0];
      for (int i = 0; i < NUM_PINS; i++) begin
         req_vec[VEC_PIN_BASE + 6'(i)] = pin_req[i];
         lvl_vec[VEC_PIN_BASE + 6'(i)] = state.priority_reg_a[PIN_PRIO_BIT[i]];
      end
      int_fwd = int_req_in & ~(dma_route_in & DMA_ROUTABLE);
      for (int i = 0; i < NUM_INT; i++) begin
         req_vec[INT_VEC[i]] = int_fwd[i];
         lvl_vec[INT_VEC[i]] = prio[INT_PRIO_BIT[i]];
      end

      // Lowest vector wins within a level
      for (int v = 63; v >= 0; v--) begin
         if (req_vec[v] && lvl_vec[v]) begin
            found_hi = 1'b1;
            sel_hi   = 6'(v);
         end
         if (req_vec[v] && !lvl_vec[v]) begin
            found_lo = 1'b1;
            sel_lo   = 6'(v);
         end
      end

      if (state.nmi_pending) begin
         next_state.req     = 1'b1;
         next_state.nmi_req = 1'b1;
         next_state.vector  = VEC_NMI;
         next_state.level   = 1'b1;
      end else if (found_hi) begin
         next_state.req     = 1'b1;
         next_state.nmi_req = 1'b0;
         next_state.vector  = sel_hi;
         next_state.level   = 1'b1;
      end else begin
         next_state.req     = found_lo;
         next_state.nmi_req = 1'b0;
         next_state.vector  = sel_lo;
         next_state.level   = 1'b0;
      end
      next_state.vec_addr_adv  = {8'h00, next_state.vector, 2'b00};
      next_state.vec_addr_norm = {9'h000, next_state.vector, 1'b0};

      next_state.wake = sw_standby_in
                        && (state.nmi_pending
                            || |pin_req[NUM_WAKE_PINS-1:0]);
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge sys_clk_in) begin
      if (rst_in || hw_standby_in) begin
         state                    <= '0;
         state.irq_sense_select   <= RST_REG8;
         state.irq_enable_reg     <= RST_REG8;
         state.irq_flag_reg       <= RST_FLAG6;
         state.priority_reg_a     <= RST_REG8;
         state.priority_reg_b     <= RST_REG8;
         state.system_control_reg <= RST_REG8;
         state.pin_prev           <= '1;
         state.nmi_prev           <= 1'b1;
         state.axi.awready        <= 1'b1;
         state.axi.wready         <= 1'b1;
         state.axi.arready        <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign s_axi_awready     = state.axi.awready;
   assign s_axi_wready      = state.axi.wready;
   assign s_axi_bvalid      = state.axi.bvalid;
   assign s_axi_bresp       = state.axi.bresp;
   assign s_axi_arready     = state.axi.arready;
   assign s_axi_rvalid      = state.axi.rvalid;
   assign s_axi_rresp       = state.axi.rresp;
   assign s_axi_rdata       = state.axi.rdata;
   assign irq_req_out       = state.req;
   assign nmi_req_out       = state.nmi_req;
   assign vector_out        = state.vector;
   assign level_out         = state.level;
   assign vec_addr_adv_out  = state.vec_addr_adv;
   assign vec_addr_norm_out = state.vec_addr_norm;
   assign wake_out          = state.wake;

endmodule
`default_nettype wire

// file: inc/eis_pkg.sv
package eis_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_SENSE_SELECT = 8'h00;
   localparam logic [7:0] OFS_ENABLE       = 8'h04;
   localparam logic [7:0] OFS_FLAG         = 8'h08;
   localparam logic [7:0] OFS_PRIO_A       = 8'h0C;
   localparam logic [7:0] OFS_PRIO_B       = 8'h10;
   localparam logic [7:0] OFS_SYS_CTRL     = 8'h14;
   localparam logic [7:0] OFS_STATUS       = 8'h18;

   // Reset values
   localparam logic [7:0] RST_REG8  = 8'h00;
   localparam logic [5:0] RST_FLAG6 = 6'h00;

   // Field positions
   localparam int NMI_EDGE_BIT  = 0;
   localparam int NUM_PINS      = 6;
   localparam int NUM_INT       = 30;
   localparam int NUM_WAKE_PINS = 3;

   // Vector numbers
   localparam logic [5:0] VEC_NMI      = 6'h07;
   localparam logic [5:0] VEC_PIN_BASE = 6'h0C;

   // Internal source vectors, index 0 upward
   localparam logic [5:0] INT_VEC [NUM_INT] = '{
      6'h14, 6'h15,
      6'h18, 6'h19, 6'h1A,
      6'h1C, 6'h1D, 6'h1E,
      6'h20, 6'h21, 6'h22,
      6'h24, 6'h25, 6'h26,
      6'h28, 6'h29, 6'h2A,
      6'h2C, 6'h2D, 6'h2E, 6'h2F,
      6'h34, 6'h35, 6'h36, 6'h37,
      6'h38, 6'h39, 6'h3A, 6'h3B,
      6'h3C};

   // Bit of {priority_reg_b, priority_reg_a} that sets each source's level
   localparam logic [3:0] INT_PRIO_BIT [NUM_INT] = '{
      4'h3, 4'h3,
      4'h2, 4'h2, 4'h2,
      4'h1, 4'h1, 4'h1,
      4'h0, 4'h0, 4'h0,
      4'hF, 4'hF, 4'hF,
      4'hE, 4'hE, 4'hE,
      4'hD, 4'hD, 4'hD, 4'hD,
      4'hB, 4'hB, 4'hB, 4'hB,
      4'hA, 4'hA, 4'hA, 4'hA,
      4'h9};

   // Pin priority bits in priority_reg_a
   localparam logic [2:0] PIN_PRIO_BIT [NUM_PINS] = '{
      3'h7, 3'h6, 3'h5, 3'h5, 3'h4, 3'h4};

   // Timer and serial sources that may be routed to DMA
   localparam logic [NUM_INT-1:0] DMA_ROUTABLE = 30'h1FE1FFFC;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
   } eis_axi_out_t;

   typedef struct packed {
      logic [7:0]  irq_sense_select;
      logic [7:0]  irq_enable_reg;
      logic [5:0]  irq_flag_reg;
      logic [7:0]  priority_reg_a;
      logic [7:0]  priority_reg_b;
      logic [7:0]  system_control_reg;
      logic [5:0]  pin_prev;
      logic        nmi_prev;
      logic        nmi_pending;
      logic        aw_got;
      logic        w_got;
      logic [7:0]  aw_addr;
      logic [7:0]  w_data;
      logic        w_lane0;
      eis_axi_out_t axi;
      logic        req;
      logic        nmi_req;
      logic [5:0]  vector;
      logic        level;
      logic [15:0] vec_addr_adv;
      logic [15:0] vec_addr_norm;
      logic        wake;
   } eis_state_t;

endpackage

// file: bench/eis_irq_front_chk.sv
`timescale 1ns/1ps
`default_nettype none
module eis_irq_front_chk
   import eis_pkg::*;
(
   input  wire logic        sys_clk_in,
   input  wire logic        rst_in,
   input  wire logic        hw_standby_in,
   input  wire logic        sw_standby_in,
   input  wire logic        nmi_pin_in,
   input  wire logic        s_axi_awvalid,
   input  wire logic        s_axi_awready,
   input  wire logic        s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic        s_axi_bvalid,
   input  wire logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic        irq_req_out,
   input  wire logic        nmi_req_out,
   input  wire logic [5:0]  vector_out,
   input  wire logic        level_out,
   input  wire logic [15:0] vec_addr_adv_out,
   input  wire logic [15:0] vec_addr_norm_out,
   input  wire logic        wake_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in || hw_standby_in);
   AST_RST: assert property (disable iff (1'b0)
      rst_in || hw_standby_in |=> !irq_req_out && !wake_out && !s_axi_bvalid)
      else $error("reset not seen");
   AST_ADDR: assert property (irq_req_out |->
      vec_addr_adv_out == {8'h00, vector_out, 2'b00} &&
      vec_addr_norm_out == {9'h000, vector_out, 1'b0}) else $error("bad vector address");
   AST_NMI: assert property (nmi_req_out |->
      irq_req_out && vector_out == VEC_NMI && level_out) else $error("bad nmi vector");
   AST_VEC: assert property (irq_req_out |-> vector_out inside
      {7, [12:17], 20, 21, [24:26], [28:30], [32:34], [36:38], [40:42], [44:47], [52:60]})
      else $error("reserved vector");
   AST_WAKE: assert property (wake_out |-> $past(sw_standby_in))
      else $error("wake outside standby");
   AST_NMI_EDGE: assert property ($rose(nmi_req_out) |->
      $past(nmi_pin_in, 2) != $past(nmi_pin_in, 3)) else $error("nmi without edge");
   AST_BRESP: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid) else $error("no write response");
   AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind eis_irq_front eis_irq_front_chk u_eis_irq_front_chk (
   .sys_clk_in(sys_clk_in), .rst_in(rst_in), .hw_standby_in(hw_standby_in),
   .sw_standby_in(sw_standby_in), .nmi_pin_in(nmi_pin_in),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .irq_req_out(irq_req_out), .nmi_req_out(nmi_req_out), .vector_out(vector_out),
   .level_out(level_out), .vec_addr_adv_out(vec_addr_adv_out),
   .vec_addr_norm_out(vec_addr_norm_out), .wake_out(wake_out));
`default_nettype wire

// file: bench/eis_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module eis_src_model
   import eis_pkg::*;
(
   input  wire logic                sys_clk_in,
   output logic                     nmi_pin_out,
   output logic [NUM_PINS-1:0]      irq_pin_n_out,
   output logic [NUM_INT-1:0]       int_req_out,
   output logic [NUM_INT-1:0]       dma_route_out
);
   // Pins idle high, used as inputs only
   initial begin
      nmi_pin_out   = 1'b1;
      irq_pin_n_out = '1;
      int_req_out   = '0;
      dma_route_out = '0;
   end
   // Levels change just after an edge
   task automatic drive(input logic n, input logic [5:0] p, input logic [29:0] q, r);
      @(posedge sys_clk_in);
      nmi_pin_out   <= n;
      irq_pin_n_out <= p;
      int_req_out   <= q;
      dma_route_out <= r;
   endtask
endmodule
`default_nettype wire

// file: bench/external_irq_sense_and_vector_map_bench.sv
`timescale 1ns/1ps
`default_nettype none
module external_irq_sense_and_vector_map_bench;
   import eis_pkg::*;
   logic        sys_clk_in = 1'b0, rst_in = 1'b1, hw_standby_in = 1'b0, sw_standby_in = 1'b0;
   logic        ack_in = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic [5:0]  ack_vector_in = 6'h00;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic        nmi_pin, awready, wready, bvalid, arready, rvalid;
   logic        irq_req, nmi_req, level, wake, route;
   logic [1:0]  bresp, rresp;
   logic [5:0]  pin_n, vec;
   logic [29:0] int_req, dma_route;
   logic [15:0] adv, norm;
   int          errors = 0, tests_run = 0, cyc = 0, i, k;

   always #25 sys_clk_in = ~sys_clk_in;

   eis_src_model u_eis_src_model (.sys_clk_in(sys_clk_in), .nmi_pin_out(nmi_pin),
      .irq_pin_n_out(pin_n), .int_req_out(int_req), .dma_route_out(dma_route));

   eis_irq_front u_eis_irq_front (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .hw_standby_in(hw_standby_in), .sw_standby_in(sw_standby_in), .nmi_pin_in(nmi_pin),
      .irq_pin_n_in(pin_n), .int_req_in(int_req), .dma_route_in(dma_route),
      .ack_in(ack_in), .ack_vector_in(ack_vector_in), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .irq_req_out(irq_req), .nmi_req_out(nmi_req),
      .vector_out(vec), .level_out(level), .vec_addr_adv_out(adv),
      .vec_addr_norm_out(norm), .wake_out(wake));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, d, input logic [1:0] er);
      @(posedge sys_clk_in);
      awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      forever begin
         @(posedge sys_clk_in);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
   endtask
   // Late rready keeps read data standing a while
   task automatic rd(input logic [7:0] a, e, input logic [1:0] er);
      @(posedge sys_clk_in);
      araddr <= a; arvalid <= 1'b1;
      forever begin
         @(posedge sys_clk_in);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b1;
      @(posedge sys_clk_in);
      rready <= 1'b0;
      chk(rdata, {24'h0, e});
      chk({30'h0, rresp}, {30'h0, er});
   endtask
   task automatic look(input logic r, input logic [5:0] v);
      #1;
      chk({31'h0, irq_req}, {31'h0, r});
      if (r) begin
         chk({26'h0, vec}, {26'h0, v});
         chk({16'h0, adv}, {14'h0, v, 2'b00});
         chk({16'h0, norm}, {15'h0, v, 1'b0});
      end
   endtask
   task automatic pulse(input logic n, input logic [5:0] p);
      u_eis_src_model.drive(n, p, '0, '0);
      u_eis_src_model.drive(1'b1, 6'h3F, '0, '0);
      @(posedge sys_clk_in);
   endtask
   task automatic ack(input logic [5:0] v);
      ack_in <= 1'b1; ack_vector_in <= v;
      @(posedge sys_clk_in);
      ack_in <= 1'b0;
      @(posedge sys_clk_in);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge sys_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         end_sim();
      end
   end

   initial begin
      k = $urandom(32'hDCD7);
      repeat (4) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      for (i = 0; i < 6; i++) rd(8'(4 * i), 8'h00, RESP_OKAY);
      rd(8'h1C, 8'h00, RESP_SLVERR);
      wr(8'h1C, 8'hFF, RESP_SLVERR);
      wr(OFS_SENSE_SELECT, 8'hC0, RESP_OKAY);
      rd(OFS_SENSE_SELECT, 8'hC0, RESP_OKAY);
      wr(OFS_ENABLE, 8'h01, RESP_OKAY);
      u_eis_src_model.drive(1'b1, 6'h3E, '0, '0);
      repeat (2) @(posedge sys_clk_in);
      look(1'b1, VEC_PIN_BASE);
      rd(OFS_FLAG, 8'h01, RESP_OKAY);
      u_eis_src_model.drive(1'b1, 6'h3F, '0, '0);
      wr(OFS_FLAG, 8'h00, RESP_OKAY);
      @(posedge sys_clk_in);
      look(1'b0, 6'h00);
      hw_standby_in <= 1'b1;
      @(posedge sys_clk_in);
      hw_standby_in <= 1'b0;
      rd(OFS_SENSE_SELECT, 8'h00, RESP_OKAY);
      wr(OFS_SENSE_SELECT, 8'h3F, RESP_OKAY);
      rd(OFS_ENABLE, 8'h00, RESP_OKAY);
      pulse(1'b1, 6'h3E);
      look(1'b0, 6'h00);
      rd(OFS_FLAG, 8'h01, RESP_OKAY);
      wr(OFS_FLAG, 8'h00, RESP_OKAY);
      wr(OFS_ENABLE, 8'h3F, RESP_OKAY);
      for (i = 0; i < 6; i++) begin
         pulse(1'b1, ~(6'h01 << i));
         look(1'b1, VEC_PIN_BASE + 6'(i));
         ack(VEC_PIN_BASE + 6'(i));
         look(1'b0, 6'h00);
      end
      pulse(1'b1, 6'h36);
      look(1'b1, 6'h0C);
      chk({31'h0, level}, 32'h0);
      wr(OFS_PRIO_A, 8'h20, RESP_OKAY);
      @(posedge sys_clk_in);
      look(1'b1, 6'h0F);
      chk({31'h0, level}, 32'h1);
      ack(6'h0F);
      sw_standby_in <= 1'b1;
      @(posedge sys_clk_in);
      #1 chk({31'h0, wake}, 32'h1);
      ack(6'h0C);
      pulse(1'b1, 6'h1F);
      #1 chk({31'h0, wake}, 32'h0);
      ack(6'h11);
      sw_standby_in <= 1'b0;
      wr(OFS_SYS_CTRL, 8'h01, RESP_OKAY);
      u_eis_src_model.drive(1'b0, 6'h3E, '0, '0);
      pulse(1'b1, 6'h3F);
      look(1'b1, VEC_NMI);
      chk({31'h0, nmi_req}, 32'h1);
      ack(VEC_NMI);
      look(1'b1, VEC_PIN_BASE);
      ack(VEC_PIN_BASE);
      look(1'b0, 6'h00);
      for (k = 0; k < 10; k++) begin
         i = $urandom % 30;
         route = 1'($urandom);
         u_eis_src_model.drive(1'b1, 6'h3F, 30'h1 << i, 30'(route) << i);
         repeat (3) @(posedge sys_clk_in);
         if (route && ((i >= 2 && i <= 16) || (i >= 21 && i <= 28))) look(1'b0, 6'h00);
         else look(1'b1, INT_VEC[i]);
         u_eis_src_model.drive(1'b1, 6'h3F, '0, '0);
         repeat (3) @(posedge sys_clk_in);
      end
      end_sim();
   end
endmodule
`default_nettype wire
